/* File: core/pad_sync.sv */
// two flip-flop synchroniser for pad inputs
`timescale 1ns/1ps
`default_nettype none
module pad_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* File: core/pin_function_select.sv */
// port a pin function selection, external clock source choice and reset pad
// Summary of operation
// - after reset every pad carries its primary, first-listed function
// - alternate function needs both port peripheral enable and pin select bits
// - external clock pad becomes the clock source only with clock mode set
// - source select bit picks clock-in pad or crystal pad
// - reset pad low holds the internal reset and config registers in reset; pad synchronisers and gpio data in keep sampling
// - internal reset releases synchronously after a fixed cycle count
// - reset pad as port a bit 7 ignores reset; other sources remain
// - reset pad defaults to reset function after reset
// - every port pin in gpio mode is independently input or output
// - pads 0..2 default gpio; alternate carries pwm channels 0..2 out
`timescale 1ns/1ps
`default_nettype none
module pin_function_select
    import pin_mux_pkg::*;
#(
    parameter int RELEASE = pin_mux_pkg::RELEASE_CYCLES
) (
    // clock and chip reset (power-on, watchdog and software reset combined)
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // software configuration, port a
    input wire logic [7:0] i_periph_enable,
    input wire logic [7:0] i_pin_periph_select,
    input wire logic [7:0] i_gpio_dir_out,
    input wire logic [7:0] i_gpio_data_out,
    // software configuration, oscillator control
    input wire logic i_clock_mode_bit,
    input wire logic i_ext_source_select_bit,
    // peripheral side
    input wire logic [2:0] i_pwm_out,
    output logic [7:0] o_gpio_data_in,
    // pads of port a, bit 7 is the reset pad
    input wire logic [7:0] i_pad_in,
    output logic [7:0] o_pad_out,
    output logic [7:0] o_pad_oe,
    // external clock pads
    input wire logic i_ext_clock_in_pad_pad,
    input wire logic i_crystal_pad,
    // clock status
    output logic o_ext_clock_active,
    output logic o_ext_clock_level,
    output logic o_crystal_selected,
    // internal reset and reset pad status
    output logic o_sys_rst_n,
    output logic o_reset_pad_mode
);
    // configuration registers, loaded from software ports each cycle while the internal reset is high
    logic [7:0] per_reg;
    logic [7:0] sel_reg;
    logic [7:0] dir_reg;
    logic [7:0] dout_reg;
    logic clk_mode_reg;
    logic ext_source_select_bit_reg;
    // synchronised pads
    logic [7:0] pad_sync;
    logic [1:0] ext_clk_sync;

    pad_sync #(
        .WIDTH(8),
        .RST_VAL(8'hff)
    ) u_pad_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_pad_in),
        .o_sync(pad_sync)
    );

    pad_sync #(
        .WIDTH(2),
        .RST_VAL(2'h0)
    ) u_clk_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_crystal_pad, i_ext_clock_in_pad_pad}),
        .o_sync(ext_clk_sync)
    );

    // alternate routing needs both the port enable and the pin select
    wire [7:0] alt_sel = per_reg & sel_reg;
    // reset pad is port a bit 7 only when software moves it there
    wire reset_pad_is_gpio = alt_sel[RESET_PAD_BIT];
    // the pad pulls up; a low level is a reset request
    wire pad_reset_req = ~reset_pad_is_gpio & ~pad_sync[RESET_PAD_BIT];

    logic [7:0] out_next;
    logic [7:0] oe_next;

    genvar g;
    generate
        for (g = 0; g < PORT_WIDTH; g++) begin : g_pad
            if (g < PWM_PADS) begin : g_pwm
                // alternate drives the pwm channel as an output
                assign out_next[g] = alt_sel[g] ? i_pwm_out[g] : dout_reg[g];
                assign oe_next[g] = alt_sel[g] | dir_reg[g];
            end else if (g == RESET_PAD_BIT) begin : g_rst
                // primary function is the reset input, never driven
                assign out_next[g] = reset_pad_is_gpio & dout_reg[g];
                assign oe_next[g] = reset_pad_is_gpio & dir_reg[g];
            end else begin : g_gpio
                // alternates of these pads belong to other peripherals
                assign out_next[g] = dout_reg[g];
                assign oe_next[g] = ~alt_sel[g] & dir_reg[g];
            end
        end
    endgenerate

    // clock source: crystal or clock-in, effective only with mode bit set
    wire src_level = (ext_src_t'(ext_source_select_bit_reg) == SRC_CRYSTAL_PAD) ?
        ext_clk_sync[1] : ext_clk_sync[0];
    wire ext_active_next = clk_mode_reg;

    // the config flops sit on the chip reset; the reset pad also loads their reset
    // values while the internal reset stays low, so software must reprogram after
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            per_reg <= PERIPH_EN_RST;
            sel_reg <= PERIPH_SEL_RST;
            dir_reg <= DIR_RST;
            dout_reg <= DATA_RST;
            clk_mode_reg <= 1'b0;
            ext_source_select_bit_reg <= 1'b0;
        end else if (!o_sys_rst_n) begin
            per_reg <= PERIPH_EN_RST;
            sel_reg <= PERIPH_SEL_RST;
            dir_reg <= DIR_RST;
            dout_reg <= DATA_RST;
            clk_mode_reg <= 1'b0;
            ext_source_select_bit_reg <= 1'b0;
        end else begin
            per_reg <= i_periph_enable;
            sel_reg <= i_pin_periph_select;
            dir_reg <= i_gpio_dir_out;
            dout_reg <= i_gpio_data_out;
            clk_mode_reg <= i_clock_mode_bit;
            ext_source_select_bit_reg <= i_ext_source_select_bit;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pad_out <= 8'h00;
            o_pad_oe <= 8'h00;
            o_gpio_data_in <= 8'h00;
            o_ext_clock_active <= 1'b0;
            o_ext_clock_level <= 1'b0;
            o_crystal_selected <= 1'b0;
            o_reset_pad_mode <= 1'b1;
        end else begin
            o_pad_out <= out_next;
            o_pad_oe <= oe_next;
            o_gpio_data_in <= pad_sync;
            o_ext_clock_active <= ext_active_next;
            o_ext_clock_level <= ext_active_next & src_level;
            o_crystal_selected <= ext_source_select_bit_reg;
            o_reset_pad_mode <= ~reset_pad_is_gpio;
        end
    end

    reset_release #(
        .RELEASE(RELEASE)
    ) u_reset_release (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_req(pad_reset_req),
        .o_sys_rst_n(o_sys_rst_n)
    );
endmodule
`default_nettype wire

/* File: core/pin_mux_pkg.sv */
// constants shared by the pin function select block
package pin_mux_pkg;
    // port a has eight pads; bit 7 doubles as the reset pad
    localparam int PORT_WIDTH = 8;
    localparam int RESET_PAD_BIT = 7;
    localparam int PWM_PADS = 3;
    // clock figures
    localparam int CLK_PERIOD_NS = 20;
    // fixed reset release delay, internal clock cycles
    localparam int RELEASE_CYCLES = 32;
    localparam int RELEASE_CNT_W = 6;
    // values after reset
    localparam logic [7:0] PERIPH_EN_RST = 8'h00;
    localparam logic [7:0] PERIPH_SEL_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    // external clock source choices
    typedef enum logic {
        SRC_EXT_CLOCK_IN_PAD_PAD,
        SRC_CRYSTAL_PAD
    } ext_src_t;
    // reset sequencer states
    typedef enum logic [1:0] {
        RST_HOLD,
        RST_COUNT,
        RST_RUN
    } rst_state_t;
endpackage

/* File: core/reset_release.sv */
// reset pad sequencer: holds internal reset, releases after a fixed count
`timescale 1ns/1ps
`default_nettype none
module reset_release
    import pin_mux_pkg::*;
#(
    parameter int RELEASE = pin_mux_pkg::RELEASE_CYCLES
) (
    // clock and power-on reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // synchronised reset request, active high
    input wire logic i_req,
    // internal reset, active low
    output logic o_sys_rst_n
);
    rst_state_t state_reg;
    rst_state_t state_next;
    logic [RELEASE_CNT_W-1:0] cnt_reg;
    logic [RELEASE_CNT_W-1:0] cnt_next;
    wire cnt_done = (cnt_reg == RELEASE_CNT_W'(RELEASE - 1));

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            RST_HOLD: begin
                cnt_next = '0;
                if (!i_req) begin
                    state_next = RST_COUNT;
                end
            end
            RST_COUNT: begin
                cnt_next = cnt_reg + 1'b1;
                if (i_req) begin
                    state_next = RST_HOLD;
                end else if (cnt_done) begin
                    state_next = RST_RUN;
                end
            end
            RST_RUN: begin
                if (i_req) begin
                    state_next = RST_HOLD;
                end
            end
            // the spare two-bit code falls back into reset rather than running
            default: begin
                state_next = RST_HOLD;
                cnt_next = '0;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= RST_HOLD;
            cnt_reg <= '0;
            o_sys_rst_n <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            o_sys_rst_n <= (state_next == RST_RUN);
        end
    end
endmodule
`default_nettype wire

/* File: test/pad_board.sv */
// board model: drives port a pads and the external clock pads
`timescale 1ns/1ps
`default_nettype none
module pad_board (
    input wire logic [7:0] i_drv_en,
    input wire logic [7:0] i_drv_val,
    input wire logic [7:0] i_dut_oe,
    input wire logic [7:0] i_dut_out,
    input wire logic i_clk_lvl,
    output logic [7:0] o_pad,
    output logic o_ext_clock_in_pad,
    output logic o_crystal
);
    // a pad nobody drives rises through its pull-up
    assign o_pad = (i_dut_oe & i_dut_out) | (~i_dut_oe & (i_drv_val | ~i_drv_en));
    assign o_ext_clock_in_pad = i_clk_lvl;
    // antiphase so a wrong source pick shows
    assign o_crystal = ~i_clk_lvl;
endmodule
`default_nettype wire

/* File: test/pin_function_select_monitor.sv */
// port checker for the pin function select block
`timescale 1ns/1ps
`default_nettype none
module pin_function_select_monitor #(
    parameter int RELEASE = 32
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_periph_enable,
    input wire logic [7:0] i_pin_periph_select,
    input wire logic [7:0] i_gpio_dir_out,
    input wire logic [2:0] i_pwm_out,
    input wire logic [7:0] i_pad_in,
    input wire logic [7:0] o_pad_out,
    input wire logic [7:0] o_pad_oe,
    input wire logic o_sys_rst_n,
    input wire logic o_reset_pad_mode
);
    // slack covers the two synchroniser flops and the output flop
    localparam int REL_HI = RELEASE + 8;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    reset_values_a: assert property ($rose(i_rst_n) |-> o_reset_pad_mode && !o_sys_rst_n)
        else $error("wrong state after reset");
    release_delay_a: assert property ($rose(i_rst_n) |-> (!o_sys_rst_n)[*4] ##[1:REL_HI] o_sys_rst_n)
        else $error("reset release out of window");
    pad_reset_a: assert property (!i_pad_in[7] && o_reset_pad_mode |-> ##[1:4] !o_sys_rst_n)
        else $error("reset pad low ignored");
    reset_quiet_a: assert property ((!o_sys_rst_n)[*3] |-> o_pad_oe == 8'h00)
        else $error("pads driven in reset");
    reassign_ign_a: assert property ((!o_reset_pad_mode)[*2] ##0 o_sys_rst_n |=> o_sys_rst_n)
        else $error("reassigned pad caused reset");
    reassign_a: assert property (
        (i_periph_enable[7] && i_pin_periph_select[7] && o_sys_rst_n)[*4] |-> !o_reset_pad_mode)
        else $error("reset pad not reassigned");
    pwm_route_a: assert property (
        (i_periph_enable[0] && i_pin_periph_select[0] && o_sys_rst_n)[*4]
        |-> o_pad_oe[0] && o_pad_out[0] == $past(i_pwm_out[0]))
        else $error("pwm not routed to pad 0");
    gpio_dir_a: assert property (
        (!i_periph_enable[1] && o_sys_rst_n && $stable(i_gpio_dir_out[1]))[*4]
        |-> o_pad_oe[1] == i_gpio_dir_out[1])
        else $error("gpio direction not applied");
endmodule
bind pin_function_select pin_function_select_monitor #(.RELEASE(RELEASE)) u_monitor (
    .i_ref_clk, .i_rst_n, .i_periph_enable, .i_pin_periph_select, .i_gpio_dir_out,
    .i_pwm_out, .i_pad_in, .o_pad_out, .o_pad_oe, .o_sys_rst_n, .o_reset_pad_mode
);
`default_nettype wire

/* File: test/pin_function_select_tb_top.sv */
// self-checking bench for the pin function select block
`timescale 1ns/1ps
`default_nettype none
module pin_function_select_tb_top;
    import pin_mux_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] per = 8'h00, sel = 8'h00, dir = 8'h00, dout = 8'h00, den = 8'h00, dval = 8'h00;
    logic [2:0] pwm = 3'h0;
    logic mode = 1'b0, src = 1'b0, lvl = 1'b0;
    logic [7:0] pad, din, pout, poe;
    logic ext_clock_in_pad, crystal_pad, active, level, xsel, sys_n, pmode;
    int fail_count = 0;
    int tests_run = 0;
    pin_function_select #(.RELEASE(4)) u_pin_function_select (
        .i_ref_clk, .i_rst_n, .i_periph_enable(per), .i_pin_periph_select(sel),
        .i_gpio_dir_out(dir), .i_gpio_data_out(dout), .i_clock_mode_bit(mode),
        .i_ext_source_select_bit(src), .i_pwm_out(pwm), .o_gpio_data_in(din), .i_pad_in(pad),
        .o_pad_out(pout), .o_pad_oe(poe), .i_ext_clock_in_pad_pad(ext_clock_in_pad), .i_crystal_pad(crystal_pad),
        .o_ext_clock_active(active), .o_ext_clock_level(level), .o_crystal_selected(xsel),
        .o_sys_rst_n(sys_n), .o_reset_pad_mode(pmode));
    pad_board u_pad_board (.i_drv_en(den), .i_drv_val(dval), .i_dut_oe(poe), .i_dut_out(pout),
        .i_clk_lvl(lvl), .o_pad(pad), .o_ext_clock_in_pad(ext_clock_in_pad), .o_crystal(crystal_pad));
    initial begin
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // waits past the sync, register and output flops before anything is read
    task automatic cfg(input logic [7:0] p, input logic [7:0] s, input logic [7:0] d);
        per <= p;
        sel <= s;
        dir <= d;
        repeat (8) @(posedge i_ref_clk);
    endtask
    task automatic wait_run();
        int n = 0;
        while (sys_n !== 1'b1 && n < 60) begin
            @(posedge i_ref_clk);
            n++;
        end
        chk({7'h00, sys_n}, 8'h01);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        wait_run();
        chk({7'h00, pmode}, 8'h01);
        chk(poe, 8'h00);
        chk(pout, 8'h00);
        dout <= 8'h55;
        cfg(8'h00, 8'hff, 8'h7f);
        chk(poe & 8'h7f, 8'h7f);
        chk(pout & 8'h7f, 8'h55);
        chk(din, 8'hd5);
        den <= 8'hf0;
        dval <= 8'ha0;
        cfg(8'h00, 8'h00, 8'h0f);
        chk(din, 8'ha5);
        $display("test gpio done");
        den <= 8'h00;
        cfg(8'h07, 8'h05, 8'h00);
        chk(poe & 8'h07, 8'h05);
        for (int i = 0; i < 8; i++) begin
            pwm <= 3'(i);
            cfg(8'h07, 8'h07, 8'h00);
            chk({2'h0, pout[2:0], poe[2:0]}, {2'h0, 3'(i), 3'h7});
        end
        $display("test pwm done");
        for (int i = 0; i < 8; i++) begin
            mode <= i[0];
            src <= i[1];
            lvl <= i[2];
            cfg(8'h00, 8'h00, 8'h00);
            chk({5'h00, active, xsel, level}, {5'h00, i[0], i[1], i[0] & (i[1] ^ i[2])});
        end
        $display("test clock done");
        dval <= 8'h00;
        den <= 8'h80;
        cfg(8'h00, 8'h00, 8'h7f);
        chk({7'h00, sys_n}, 8'h00);
        chk(poe, 8'h00);
        den <= 8'h00;
        wait_run();
        $display("test reset pad done");
        cfg(8'h80, 8'h80, 8'h00);
        chk({7'h00, pmode}, 8'h00);
        den <= 8'h80;
        cfg(8'h80, 8'h80, 8'h00);
        chk({7'h00, sys_n}, 8'h01);
        chk(din & 8'h80, 8'h00);
        i_rst_n <= 1'b0;
        den <= 8'h00;
        cfg(8'h00, 8'h00, 8'h00);
        i_rst_n <= 1'b1;
        wait_run();
        chk({7'h00, pmode}, 8'h01);
        $display("test reassign done");
        close_out();
    end
    initial begin
        repeat (3000) @(posedge i_ref_clk);
        fail_count++;
        close_out();
    end
endmodule
`default_nettype wire
